// ==== logic/fic_pkg.sv ====
// Package of opcodes, status layout and link sequencing constants
package fic_pkg;

  // Opcodes taken from the serial input
  localparam logic [7:0] FIC_OPC_ID_QUERY     = 8'h90;
  localparam logic [7:0] FIC_OPC_LATCH_SET    = 8'h06;
  localparam logic [7:0] FIC_OPC_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] FIC_OPC_STATUS_READ  = 8'h05;
  localparam logic [7:0] FIC_OPC_PAR_ENTER    = 8'h55;
  localparam logic [7:0] FIC_OPC_PAR_EXIT     = 8'h45;

  // Frame sequencing: opcode byte then three address bytes
  localparam logic [2:0] FIC_LAST_BIT         = 3'h7;
  localparam logic [2:0] FIC_OPC_BYTE         = 3'h0;
  localparam logic [2:0] FIC_LAST_ADDR_BYTE   = 3'h3;
  localparam logic [2:0] FIC_BYTE_CNT_MAX     = 3'h4;

  // Status byte field positions
  localparam int FIC_SR_LOCK_POS    = 7;
  localparam int FIC_SR_SPARE_POS   = 6;
  localparam int FIC_SR_PROT_HI_POS = 5;
  localparam int FIC_SR_PROT_LO_POS = 2;
  localparam int FIC_SR_WEL_POS     = 1;
  localparam int FIC_SR_WIP_POS     = 0;

  // Reset values
  localparam logic [7:0] FIC_STATUS_RST = 8'h00;
  localparam logic [7:0] FIC_BYTE_RST   = 8'h00;

  // Link phases
  typedef enum logic [2:0] {
    FIC_PH_OPCODE,
    FIC_PH_ADDR,
    FIC_PH_ID_OUT,
    FIC_PH_SR_OUT,
    FIC_PH_IGNORE
  } fic_phase_e;

endpackage : fic_pkg

// ==== logic/fic_id_status.sv ====
// Command decoder for identity query, write latch and status read commands
//
// Behaviour
// - Opcode 90h then 24 address bits starts identity bytes on serial output.
// - Address LSB 0 gives maker byte first, LSB 1 gives device byte first.
// - Address bits above the lowest are ignored in the identity query.
// - Each identity byte leaves the serial output MSB first.
// - Identity output alternates both bytes while chip select stays low.
// - Chip select rising after identity query enters standby; falling leaves it.
// - Opcode 55h enters byte-wide mode, 45h or power cycle leaves it.
// - Byte-wide mode drives a whole byte per clock, same sequence as serial.
// - Opcode 06h sets the write enable latch.
// - Opcode 04h clears the write enable latch.
// - Latch clears at reset and on completion of clear, write, program, erase.
// - Status read opcode 05h is accepted at any time, even when busy.
// - Status read repeats the live status byte until chip select rises.
// - Large variant: lock bit7, bit5 zero, protect 4..2, latch bit1, busy bit0.
// - Small variant widens the protect field to bits 5..2.
// - Lock bit with low protect pin gives status protection, else none.
// - Busy bit reads 1 while an internal operation runs, else 0.
// - Latch and mode commands run only when deselected on a byte boundary.
// - Busy bit only from internal logic; status write cannot set the latch.
module fic_id_status
  import fic_pkg::*;
#(
  parameter logic [7:0] MAKER_ID     = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEVICE_ID    = 8'h5A, // Arbitrary value
  parameter bit         SMALL_SECTOR = 1'b0
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial link pins
  input  wire logic       serial_clock,
  input  wire logic       chip_sel_n,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe_n,
  output logic [7:0]      parallel_out_bus,
  output logic            parallel_out_oe_n,
  input  wire logic       write_protect_pin,
  // Internal operation engine side
  input  wire logic       op_busy_in,
  input  wire logic       op_done_in,
  input  wire logic       nv_lock_in,
  input  wire logic [3:0] nv_protect_in,
  // Device state
  output logic            write_enable_latch,
  output logic            parallel_mode,
  output logic            standby_mode,
  output logic            status_protect,
  output logic [7:0]      status_byte
);

  function automatic logic msb_first_bit(input logic [7:0] b, input logic [2:0] idx);
    msb_first_bit = b[FIC_LAST_BIT - idx];
  endfunction : msb_first_bit

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain, clocked by serial_clock; the decoder and output drive are cleared by deselection

  logic       link_rst;
  fic_phase_e phase_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] out_bit_reg;
  logic       out_sel_reg;
  logic       addr_lsb_reg;
  logic [7:0] opcode_lk_reg;
  logic       aligned_lk_reg;
  logic       frame_tog_reg;
  logic [7:0] sr_sync1_reg;
  logic [7:0] sr_sync2_reg;
  logic       par_sync1_reg;
  logic       par_sync2_reg;
  logic [7:0] cur_byte;
  logic       out_phase;

  // Deselection clears the link decoder without needing a clock edge
  assign link_rst   = rst | chip_sel_n;
  assign shift_next = {shift_reg[6:0], serial_in};
  assign out_phase  = (phase_reg == FIC_PH_ID_OUT) || (phase_reg == FIC_PH_SR_OUT);

  always_ff @(posedge serial_clock or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg    <= FIC_BYTE_RST;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= shift_next;
      if (bit_cnt_reg == FIC_LAST_BIT && byte_cnt_reg != FIC_BYTE_CNT_MAX) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge serial_clock or posedge link_rst) begin
    if (link_rst) begin
      phase_reg    <= FIC_PH_OPCODE;
      addr_lsb_reg <= 1'b0;
    end else begin
      case (phase_reg)
        FIC_PH_OPCODE: begin
          if (bit_cnt_reg == FIC_LAST_BIT) begin
            if (shift_next == FIC_OPC_ID_QUERY) begin
              phase_reg <= FIC_PH_ADDR;
            end else if (shift_next == FIC_OPC_STATUS_READ) begin
              phase_reg <= FIC_PH_SR_OUT;
            end else begin
              phase_reg <= FIC_PH_IGNORE;
            end
          end
        end
        FIC_PH_ADDR: begin
          if (bit_cnt_reg == FIC_LAST_BIT && byte_cnt_reg == FIC_LAST_ADDR_BYTE) begin
            addr_lsb_reg <= serial_in;
            phase_reg    <= FIC_PH_ID_OUT;
          end
        end
        FIC_PH_ID_OUT: phase_reg <= FIC_PH_ID_OUT;
        FIC_PH_SR_OUT: phase_reg <= FIC_PH_SR_OUT;
        FIC_PH_IGNORE: phase_reg <= FIC_PH_IGNORE;
        default:       phase_reg <= FIC_PH_IGNORE;
      endcase
    end
  end

  // Output position advances on each rising edge once output has started
  always_ff @(posedge serial_clock or posedge link_rst) begin
    if (link_rst) begin
      out_bit_reg <= 3'h0;
      out_sel_reg <= 1'b0;
    end else if (out_phase) begin
      if (par_sync2_reg) begin
        out_sel_reg <= ~out_sel_reg;
      end else begin
        out_bit_reg <= out_bit_reg + 3'h1;
        if (out_bit_reg == FIC_LAST_BIT) begin
          out_sel_reg <= ~out_sel_reg;
        end
      end
    end
  end

  // Kept across deselection so the system side can read them after the frame
  always_ff @(posedge serial_clock or posedge rst) begin
    if (rst) begin
      opcode_lk_reg  <= FIC_BYTE_RST;
      aligned_lk_reg <= 1'b0;
      frame_tog_reg  <= 1'b0;
    end else begin
      aligned_lk_reg <= (bit_cnt_reg == FIC_LAST_BIT);
      if (bit_cnt_reg == FIC_LAST_BIT && byte_cnt_reg == FIC_OPC_BYTE) begin
        opcode_lk_reg <= shift_next;
        frame_tog_reg <= ~frame_tog_reg;
      end
    end
  end

  // Status flags and mode are independent levels, each bit synchronised alone
  always_ff @(posedge serial_clock or posedge rst) begin
    if (rst) begin
      sr_sync1_reg  <= FIC_STATUS_RST;
      sr_sync2_reg  <= FIC_STATUS_RST;
      par_sync1_reg <= 1'b0;
      par_sync2_reg <= 1'b0;
    end else begin
      sr_sync1_reg  <= status_byte;
      sr_sync2_reg  <= sr_sync1_reg;
      par_sync1_reg <= parallel_mode;
      par_sync2_reg <= par_sync1_reg;
    end
  end

  always_comb begin
    if (phase_reg == FIC_PH_SR_OUT) begin
      cur_byte = sr_sync2_reg;
    end else if (out_sel_reg ^ addr_lsb_reg) begin
      cur_byte = DEVICE_ID;
    end else begin
      cur_byte = MAKER_ID;
    end
  end

  // Falling-edge drive; deselection floats the outputs at once
  always_ff @(negedge serial_clock or posedge link_rst) begin
    if (link_rst) begin
      serial_out        <= 1'b0;
      serial_out_oe_n   <= 1'b1;
      parallel_out_bus  <= FIC_BYTE_RST;
      parallel_out_oe_n <= 1'b1;
    end else begin
      serial_out        <= msb_first_bit(cur_byte, out_bit_reg);
      serial_out_oe_n   <= ~(out_phase & ~par_sync2_reg);
      parallel_out_bus  <= cur_byte;
      parallel_out_oe_n <= ~(out_phase & par_sync2_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: frame end detection and command execution

  logic cs_sync1_reg;
  logic cs_sync2_reg;
  logic cs_prev_reg;
  logic tog_sync1_reg;
  logic tog_sync2_reg;
  logic tog_seen_reg;
  logic al_sync1_reg;
  logic al_sync2_reg;
  logic wp_sync1_reg;
  logic wp_sync2_reg;
  logic cs_rise;
  logic cs_fall;
  logic new_opcode;
  logic exec_evt;
  logic set_evt;
  logic clear_evt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_sync1_reg  <= 1'b1;
      cs_sync2_reg  <= 1'b1;
      cs_prev_reg   <= 1'b1;
      tog_sync1_reg <= 1'b0;
      tog_sync2_reg <= 1'b0;
      al_sync1_reg  <= 1'b0;
      al_sync2_reg  <= 1'b0;
      wp_sync1_reg  <= 1'b1;
      wp_sync2_reg  <= 1'b1;
    end else begin
      cs_sync1_reg  <= chip_sel_n;
      cs_sync2_reg  <= cs_sync1_reg;
      cs_prev_reg   <= cs_sync2_reg;
      tog_sync1_reg <= frame_tog_reg;
      tog_sync2_reg <= tog_sync1_reg;
      al_sync1_reg  <= aligned_lk_reg;
      al_sync2_reg  <= al_sync1_reg;
      wp_sync1_reg  <= write_protect_pin;
      wp_sync2_reg  <= wp_sync1_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_seen_reg <= 1'b0;
    end else if (cs_rise) begin
      tog_seen_reg <= tog_sync2_reg;
    end
  end

  // Opcode is still while the link is deselected, so the frame end qualifies it
  assign cs_rise    = cs_sync2_reg & ~cs_prev_reg;
  assign cs_fall    = ~cs_sync2_reg & cs_prev_reg;
  assign new_opcode = cs_rise & (tog_sync2_reg != tog_seen_reg);
  assign exec_evt   = new_opcode & al_sync2_reg;
  assign set_evt    = exec_evt && (opcode_lk_reg == FIC_OPC_LATCH_SET);
  assign clear_evt  = (exec_evt && (opcode_lk_reg == FIC_OPC_LATCH_CLEAR)) || op_done_in;

  // Set wins over a completion arriving in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (set_evt) begin
      write_enable_latch <= 1'b1;
    end else if (clear_evt) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parallel_mode <= 1'b0;
    end else if (exec_evt && opcode_lk_reg == FIC_OPC_PAR_ENTER) begin
      parallel_mode <= 1'b1;
    end else if (exec_evt && opcode_lk_reg == FIC_OPC_PAR_EXIT) begin
      parallel_mode <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standby_mode <= 1'b0;
    end else if (new_opcode && opcode_lk_reg == FIC_OPC_ID_QUERY) begin
      standby_mode <= 1'b1;
    end else if (cs_fall) begin
      standby_mode <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_byte    <= FIC_STATUS_RST;
      status_protect <= 1'b0;
    end else begin
      status_byte[FIC_SR_LOCK_POS]  <= nv_lock_in;
      status_byte[FIC_SR_SPARE_POS] <= 1'b0;
      status_byte[FIC_SR_PROT_HI_POS] <= SMALL_SECTOR ? nv_protect_in[3] : 1'b0;
      status_byte[FIC_SR_PROT_HI_POS-1:FIC_SR_PROT_LO_POS] <= nv_protect_in[2:0];
      status_byte[FIC_SR_WEL_POS]   <= write_enable_latch;
      status_byte[FIC_SR_WIP_POS]   <= op_busy_in;
      status_protect <= nv_lock_in & ~wp_sync2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  a_latch_set_exec: assert property (@(posedge clk) disable iff (rst)
    set_evt |=> write_enable_latch)
    else $error("latch set did not set the write enable latch");

  a_latch_clear_exec: assert property (@(posedge clk) disable iff (rst)
    (exec_evt && opcode_lk_reg == FIC_OPC_LATCH_CLEAR) |=> !write_enable_latch)
    else $error("latch clear did not clear the write enable latch");

  a_done_clears_latch: assert property (@(posedge clk) disable iff (rst)
    (op_done_in && !set_evt) |=> !write_enable_latch)
    else $error("completion did not clear the write enable latch");

  a_misaligned_ignored: assert property (@(posedge clk) disable iff (rst)
    (new_opcode && !al_sync2_reg && !op_done_in) |=> $stable(write_enable_latch)
      && $stable(parallel_mode))
    else $error("command executed without a byte boundary");

  a_par_mode_track: assert property (@(posedge clk) disable iff (rst)
    (exec_evt && opcode_lk_reg == FIC_OPC_PAR_ENTER) |=> parallel_mode ##1 parallel_mode)
    else $error("byte-wide mode not entered");

  a_busy_bit_track: assert property (@(posedge clk) disable iff (rst)
    ##1 status_byte[FIC_SR_WIP_POS] == $past(op_busy_in))
    else $error("busy bit does not follow internal operation");

  a_wel_in_status: assert property (@(posedge clk) disable iff (rst)
    set_evt |=> ##1 status_byte[FIC_SR_WEL_POS])
    else $error("latch bit missing from status byte");

  a_spare_bits_zero: assert property (@(posedge clk) disable iff (rst)
    !status_byte[FIC_SR_SPARE_POS] && (SMALL_SECTOR || !status_byte[FIC_SR_PROT_HI_POS]))
    else $error("unused status bits not zero");

  a_protect_level: assert property (@(posedge clk) disable iff (rst)
    (nv_lock_in && !wp_sync2_reg) |=> status_protect)
    else $error("status protection not applied");

  a_standby_entry: assert property (@(posedge clk) disable iff (rst)
    (new_opcode && opcode_lk_reg == FIC_OPC_ID_QUERY) |=> standby_mode)
    else $error("no standby after identity query");

  a_outputs_float: assert property (@(posedge clk) disable iff (rst)
    (cs_sync2_reg && cs_prev_reg) |-> serial_out_oe_n && parallel_out_oe_n)
    else $error("outputs driven while deselected");

  c_latch_set:   cover property (@(posedge clk) disable iff (rst) set_evt);
  c_par_enter:   cover property (@(posedge clk) disable iff (rst)
    exec_evt && opcode_lk_reg == FIC_OPC_PAR_ENTER);
  c_id_standby:  cover property (@(posedge clk) disable iff (rst) $rose(standby_mode));
  c_status_busy: cover property (@(posedge clk) disable iff (rst)
    !serial_out_oe_n && status_byte[FIC_SR_WIP_POS]);

endmodule : fic_id_status

// ==== test/fic_host_model.sv ====
// Host controller model that drives the serial flash link
module fic_host_model (
  // Link pins
  output logic            serial_clock,
  output logic            chip_sel_n,
  output logic            serial_in,
  input  wire logic       serial_out,
  input  wire logic [7:0] parallel_out_bus,
  // Output enables, watched to see which path the device drives
  input  wire logic       serial_out_oe_n,
  input  wire logic       parallel_out_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] rx[$];
  logic       so_seen;
  logic [7:0] po_seen;
  logic [1:0] oe_seen;

  initial begin
    serial_clock = 1'b0;
    chip_sel_n   = 1'b1;
    serial_in    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One link clock; sampled at the rise, device output settled since the fall
  task automatic tick(input int half, input logic bit_in);
    serial_in = bit_in;
    #half;
    serial_clock = 1'b1;
    so_seen = serial_out;
    po_seen = parallel_out_bus;
    oe_seen = {serial_out_oe_n, parallel_out_oe_n};
    #half;
    serial_clock = 1'b0;
  endtask : tick

  ////////////////////////////////////////////////////////////////////////////
  // Whole frame; clock stands low and data line toggles outside it
  task automatic frame(input logic [7:0] tx[$], input int n_extra, input int n_rx,
                       input bit par);
    int         half;
    logic [7:0] sh;
    half = par ? 60 : 24;
    rx = {};
    chip_sel_n = 1'b0;
    #half;
    foreach (tx[i]) for (int b = 7; b >= 0; b--) tick(half, tx[i][b]);
    repeat (n_extra) tick(half, 1'b0);
    repeat (n_rx) begin
      if (par) begin
        tick(half, ~serial_in);
        sh = po_seen;
      end else begin
        for (int b = 0; b < 8; b++) begin
          tick(half, ~serial_in);
          sh = {sh[6:0], so_seen};
        end
      end
      rx.push_back(sh);
    end
    #half;
    chip_sel_n = 1'b1;
    serial_in = ~serial_in;
    #(4 * half);
  endtask : frame
endmodule : fic_host_model

// ==== test/flash_id_and_status_commands_bench.sv ====
// Self-checking bench for the identity, latch and status command decoder
module flash_id_and_status_commands_bench
  import fic_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] MAK = 8'h3C; // Arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // Arbitrary value

  logic       clk, rst, serial_clock, chip_sel_n, serial_in, serial_out;
  logic       serial_out_oe_n, parallel_out_oe_n, write_protect_pin;
  logic       op_busy_in, op_done_in, nv_lock_in, write_enable_latch;
  logic       parallel_mode, standby_mode, status_protect;
  logic [7:0] parallel_out_bus, status_byte, small_status;
  logic [3:0] nv_protect_in;
  int         n_fail, n_compared;
  bit         par;

  fic_id_status #(.MAKER_ID(MAK), .DEVICE_ID(DEV)) dut (
    .clk, .rst, .serial_clock, .chip_sel_n, .serial_in, .serial_out, .serial_out_oe_n,
    .parallel_out_bus, .parallel_out_oe_n, .write_protect_pin, .op_busy_in, .op_done_in,
    .nv_lock_in, .nv_protect_in, .write_enable_latch, .parallel_mode, .standby_mode,
    .status_protect, .status_byte);

  // Small-sector variant on the same pins, only its status byte is watched
  fic_id_status #(.MAKER_ID(MAK), .DEVICE_ID(DEV), .SMALL_SECTOR(1'b1)) dut_small (
    .clk, .rst, .serial_clock, .chip_sel_n, .serial_in, .serial_out(),
    .serial_out_oe_n(), .parallel_out_bus(), .parallel_out_oe_n(), .write_protect_pin,
    .op_busy_in, .op_done_in, .nv_lock_in, .nv_protect_in, .write_enable_latch(),
    .parallel_mode(), .standby_mode(), .status_protect(), .status_byte(small_status));

  fic_host_model host (.serial_clock, .chip_sel_n, .serial_in, .serial_out,
                       .parallel_out_bus, .serial_out_oe_n, .parallel_out_oe_n);

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic flag(input string what, input logic exp, input logic got);
    chk(what, {7'h0, exp}, {7'h0, got});
  endtask : flag

  // Command execution lands a few clk cycles after deselect
  task automatic cmd(input logic [7:0] opc, input int n_extra);
    host.frame({opc}, n_extra, 0, par);
    repeat (10) @(negedge clk);
  endtask : cmd

  task automatic id_read(input logic [23:0] a);
    host.frame({FIC_OPC_ID_QUERY, a[23:16], a[15:8], a[7:0]}, 0, 4, par);
    for (int i = 0; i < 4; i++) chk("id", (i[0] ^ a[0]) ? DEV : MAK, host.rx[i]);
    chk("oe_n live", par ? 8'h02 : 8'h01, {6'h0, host.oe_seen});
    chk("oe_n", 8'h03, {6'h0, serial_out_oe_n, parallel_out_oe_n});
    repeat (10) @(negedge clk);
  endtask : id_read

  task automatic stat_read(input logic [7:0] e);
    host.frame({FIC_OPC_STATUS_READ}, 0, 3, par);
    for (int i = 0; i < 3; i++) chk("status out", e, host.rx[i]);
    chk("sr oe_n live", par ? 8'h02 : 8'h01, {6'h0, host.oe_seen});
    chk("status", e, status_byte);
    repeat (10) @(negedge clk);
  endtask : stat_read

  task automatic give_verdict;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    {clk, op_busy_in, op_done_in, nv_lock_in, write_protect_pin, par} = '0;
    nv_protect_in = 4'h0;
    rst = 1'b1;
    n_fail = 0;
    n_compared = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    flag("latch", 1'b0, write_enable_latch);
    chk("status", 8'h00, status_byte);
    id_read(24'h00_0000);
    flag("standby", 1'b1, standby_mode);
    id_read(24'hFF_FFF1);
    cmd(FIC_OPC_LATCH_SET, 0);
    flag("latch", 1'b1, write_enable_latch);
    flag("standby", 1'b0, standby_mode);
    op_done_in = 1'b1;
    @(negedge clk);
    op_done_in = 1'b0;
    repeat (3) @(negedge clk);
    flag("latch", 1'b0, write_enable_latch);
    cmd(FIC_OPC_LATCH_SET, 0);
    cmd(FIC_OPC_LATCH_CLEAR, 0);
    flag("latch", 1'b0, write_enable_latch);
    cmd(FIC_OPC_LATCH_SET, 1);
    flag("latch", 1'b0, write_enable_latch);
    cmd(FIC_OPC_LATCH_SET, 8);
    flag("latch", 1'b1, write_enable_latch);
    // Busy device still answers status reads
    nv_lock_in = 1'b1;
    nv_protect_in = 4'hB;
    op_busy_in = 1'b1;
    repeat (4) @(negedge clk);
    stat_read(8'h8F);
    chk("small status", 8'hAF, small_status);
    for (int k = 0; k < 3; k++) begin
      nv_lock_in = (k != 2);
      write_protect_pin = (k == 1);
      repeat (6) @(negedge clk);
      flag("protect", k == 0, status_protect);
    end
    op_busy_in = 1'b0;
    // Poll for idle before the next command
    repeat (4) @(negedge clk);
    stat_read(8'h0E);
    chk("small status", 8'h2E, small_status);
    cmd(FIC_OPC_PAR_ENTER, 0);
    flag("byte mode", 1'b1, parallel_mode);
    par = 1'b1;
    id_read(24'h00_0001);
    stat_read(8'h0E);
    cmd(FIC_OPC_PAR_EXIT, 0);
    par = 1'b0;
    flag("byte mode", 1'b0, parallel_mode);
    stat_read(8'h0E);
    give_verdict();
  end
endmodule : flash_id_and_status_commands_bench
